/* logic/wdru_top.sv */
// How it works
// - unlock address is the key port on write; reading it returns reset status.
// - two writes 55 then AA to the unlock address open the reload bytes.
// - key writes change no stored bits, only advance or relock the lock machine.
// - reload byte writes while locked are ignored.
// - reload value is upper, middle, lower bytes from high to low.
// - each accepted refresh copies the reload value into the down counter.
// - reload byte write updates stored reload, never the running counter.
// - reading a reload byte returns that byte of the live count.
// - reload bytes sit at FF1, FF2, FF3, eight bits, read/write.
// - bytes go upper, middle, lower; any other write relocks.
// - counter decrements on slow ticks; zero gives interrupt or reset.
// - after time-out the counter wraps to all ones and keeps going.
// - while running, refresh is ignored once the count is two or lower.
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "wdru_consts.svh"
module wdru_top
  import wdru_pkg::*;
(
  input  wire logic        clk_sys_i,   // system clock, 125 MHz
  input  wire logic        rst_i,       // async reset, active high
  input  wire logic [11:0] addr_i,      // register address
  input  wire logic [7:0]  wdata_i,     // write data
  input  wire logic        wr_i,        // write strobe
  input  wire logic        rd_i,        // read strobe
  output logic      [7:0]  rdata_o,     // read data, cycle after rd_i
  input  wire logic        osc_i,       // slow oscillator pin
  input  wire logic        refresh_i,   // refresh instruction pulse
  input  wire logic        resp_reset_i,// time-out option: 1 reset, 0 irq
  output logic             irq_o,       // level interrupt
  output logic             sys_reset_o  // one-cycle system reset request
);

  wdru_lock_e  lock_state;
  wdru_lock_e  next_lock_state;
  logic [7:0]  reload_upper;
  logic [7:0]  reload_middle;
  logic [7:0]  reload_lower;
  wdru_count_t reload_value;
  wdru_count_t count;
  logic        running;
  logic        tick;
  logic        timeout;
  logic        refresh_ok;
  logic [1:0]  rst_status;
  logic [1:0]  ev_status;
  logic [1:0]  ev_mask;
  logic        reload_done;
  logic        wr_upper;
  logic        wr_middle;
  logic        wr_lower;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] b);
    hit = (a == b);
  endfunction

  wdru_tick_sync u_tick_sync
  (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .osc_i     (osc_i),
    .tick_o    (tick)
  );

  assign reload_value = {reload_upper, reload_middle, reload_lower};

  // reload bytes accepted only in the matching open step
  assign wr_upper  = wr_i && hit(addr_i, `WDRU_ADDR_UPPER)
                     && (lock_state == WDRU_OPEN_UPPER);
  assign wr_middle = wr_i && hit(addr_i, `WDRU_ADDR_MIDDLE)
                     && (lock_state == WDRU_OPEN_MIDDLE);
  assign wr_lower  = wr_i && hit(addr_i, `WDRU_ADDR_LOWER)
                     && (lock_state == WDRU_OPEN_LOWER);
  assign reload_done = wr_lower;

  // lock machine: every write either advances it or drops it to locked
  always_comb
  begin
    next_lock_state = lock_state;
    if (wr_i)
    begin
      next_lock_state = WDRU_LOCKED;
      case (lock_state)
        WDRU_LOCKED:
        begin
          if (hit(addr_i, `WDRU_ADDR_UNLOCK) && wdata_i == `WDRU_KEY_FIRST)
            next_lock_state = WDRU_KEY1;
        end
        WDRU_KEY1:
        begin
          if (hit(addr_i, `WDRU_ADDR_UNLOCK) && wdata_i == `WDRU_KEY_SECOND)
            next_lock_state = WDRU_OPEN_UPPER;
        end
        WDRU_OPEN_UPPER:
        begin
          if (wr_upper)
            next_lock_state = WDRU_OPEN_MIDDLE;
        end
        WDRU_OPEN_MIDDLE:
        begin
          if (wr_middle)
            next_lock_state = WDRU_OPEN_LOWER;
        end
        WDRU_OPEN_LOWER:
        begin
          next_lock_state = WDRU_LOCKED;
        end
        default:
        begin
          next_lock_state = WDRU_LOCKED;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      lock_state <= WDRU_LOCKED;
    else
      lock_state <= next_lock_state;
  end

  // stored reload bytes; key writes never touch them
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      reload_upper  <= `WDRU_RST_UPPER;
      reload_middle <= `WDRU_RST_MIDDLE;
      reload_lower  <= `WDRU_RST_LOWER;
    end
    else
    begin
      if (wr_upper)
        reload_upper <= wdata_i;
      if (wr_middle)
        reload_middle <= wdata_i;
      if (wr_lower)
        reload_lower <= wdata_i;
    end
  end

  // down counter on slow ticks; refresh wins over a tick in the same cycle
  assign refresh_ok = refresh_i && (!running || count > `WDRU_REFRESH_MIN);
  assign timeout    = running && tick && !refresh_ok
                      && count == 24'h000001;

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      count   <= `WDRU_RST_COUNT;
      running <= 1'b0;
    end
    else
    begin
      if (refresh_ok)
      begin
        count   <= reload_value;
        running <= 1'b1;
      end
      else if (running && tick)
        count <= count - 24'h000001;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      sys_reset_o <= 1'b0;
    else
      sys_reset_o <= timeout && resp_reset_i;
  end

  // reset status: set wins over the clearing read
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      rst_status <= 2'h0;
    else
    begin
      if (rd_i && hit(addr_i, `WDRU_ADDR_UNLOCK))
        rst_status <= 2'h0;
      if (timeout)
        rst_status[`WDRU_RS_TIMEOUT] <= 1'b1;
      if (timeout && resp_reset_i)
        rst_status[`WDRU_RS_WDRESET] <= 1'b1;
    end
  end

  // event status, write one to clear, set wins
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      ev_status <= 2'h0;
    else
    begin
      if (wr_i && hit(addr_i, `WDRU_ADDR_IRQ_ST))
        ev_status <= ev_status & ~wdata_i[1:0];
      if (timeout && !resp_reset_i)
        ev_status[`WDRU_EV_TIMEOUT] <= 1'b1;
      if (reload_done)
        ev_status[`WDRU_EV_RELOAD] <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      ev_mask <= `WDRU_RST_IRQ_MSK;
    else if (wr_i && hit(addr_i, `WDRU_ADDR_IRQ_MSK))
      ev_mask <= wdata_i[1:0];
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      irq_o <= 1'b0;
    else
      irq_o <= |(ev_status & ev_mask);
  end

  // read mux; reload addresses show the live count
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      rdata_o <= 8'h00;
    else if (rd_i)
    begin
      case (addr_i)
        `WDRU_ADDR_UNLOCK:  rdata_o <= {6'h00, rst_status};
        `WDRU_ADDR_UPPER:   rdata_o <= count[23:16];
        `WDRU_ADDR_MIDDLE:  rdata_o <= count[15:8];
        `WDRU_ADDR_LOWER:   rdata_o <= count[7:0];
        `WDRU_ADDR_IRQ_ST:  rdata_o <= {6'h00, ev_status};
        `WDRU_ADDR_IRQ_MSK: rdata_o <= {6'h00, ev_mask};
        default:            rdata_o <= 8'h00;
      endcase
    end
    else
      rdata_o <= 8'h00;
  end

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);

  key_second_a: assert property (
    lock_state == WDRU_KEY1 && wr_i && addr_i == `WDRU_ADDR_UNLOCK
    && wdata_i == `WDRU_KEY_SECOND |=> lock_state == WDRU_OPEN_UPPER)
    else $error("second key did not open the reload bytes");

  key_no_store_a: assert property (
    wr_i && addr_i == `WDRU_ADDR_UNLOCK |=> $stable(reload_value))
    else $error("key write altered the reload value");

  locked_write_a: assert property (
    wr_i && addr_i == `WDRU_ADDR_UPPER && lock_state != WDRU_OPEN_UPPER
    |=> $stable(reload_upper))
    else $error("locked upper byte was written");

  reload_store_a: assert property (
    lock_state == WDRU_OPEN_MIDDLE && wr_i && addr_i == `WDRU_ADDR_MIDDLE
    |=> reload_middle == $past(wdata_i) && lock_state == WDRU_OPEN_LOWER)
    else $error("middle reload byte not stored");

  relock_a: assert property (
    lock_state == WDRU_OPEN_LOWER && wr_i |=> lock_state == WDRU_LOCKED)
    else $error("lock not re-engaged after lower byte");

  count_read_a: assert property (
    rd_i && addr_i == `WDRU_ADDR_LOWER |=> rdata_o == $past(count[7:0]))
    else $error("lower byte read did not return live count");

  refresh_load_a: assert property (
    refresh_i && running && count > `WDRU_REFRESH_MIN |=> count == $past(reload_value))
    else $error("refresh did not load the reload value");

  late_refresh_a: assert property (
    refresh_i && running && count <= `WDRU_REFRESH_MIN && !tick
    |=> count == $past(count))
    else $error("refresh accepted at count two or lower");

  rollover_a: assert property (
    running && tick && !refresh_i && count == 24'h000000
    |=> count == 24'hFFFFFF)
    else $error("counter did not wrap to all ones");

  reset_resp_a: assert property (
    timeout && resp_reset_i |=> sys_reset_o ##1 !sys_reset_o)
    else $error("reset response not a one-cycle pulse");

  wrong_key_a: assert property (
    lock_state == WDRU_LOCKED && wr_i
    && !(addr_i == `WDRU_ADDR_UNLOCK && wdata_i == `WDRU_KEY_FIRST) |=> lock_state == WDRU_LOCKED)
    else $error("lock left without the first key");

  locked_lower_a: assert property (
    wr_i && addr_i == `WDRU_ADDR_LOWER && lock_state != WDRU_OPEN_LOWER
    |=> $stable(reload_lower))
    else $error("locked lower byte was written");

  stray_write_a: assert property (
    lock_state == WDRU_OPEN_MIDDLE && wr_i && addr_i != `WDRU_ADDR_MIDDLE
    |=> lock_state == WDRU_LOCKED && $stable(reload_middle))
    else $error("out-of-order write did not relock");

  status_read_a: assert property (
    rd_i && addr_i == `WDRU_ADDR_UNLOCK |=> rdata_o == {6'h00, $past(rst_status)})
    else $error("unlock address read did not return reset status");

  upper_read_a: assert property (
    rd_i && addr_i == `WDRU_ADDR_UPPER |=> rdata_o == $past(count[23:16]))
    else $error("upper byte read did not return live count");

  read_idle_a: assert property (
    !rd_i |=> rdata_o == 8'h00)
    else $error("read data not cleared after its cycle");

  count_hold_a: assert property (
    !refresh_i && !tick |=> $stable(count))
    else $error("counter moved without refresh or tick");

  first_refresh_a: assert property (
    refresh_i && !running |=> running && count == $past(reload_value))
    else $error("first refresh did not start the counter");

  timeout_flag_a: assert property (
    timeout && !resp_reset_i
    |=> ev_status[`WDRU_EV_TIMEOUT] && rst_status[`WDRU_RS_TIMEOUT] && !sys_reset_o)
    else $error("interrupt time-out did not set its flags");

  tick_pulse_a: assert property (
    tick |=> !tick)
    else $error("slow tick lasted more than one cycle");

  unlock_seq_c: cover property (
    lock_state == WDRU_OPEN_LOWER && wr_i && addr_i == `WDRU_ADDR_LOWER);
  timeout_irq_c: cover property (timeout && !resp_reset_i ##[1:3] irq_o);
  refresh_c: cover property (refresh_ok && running);
  late_refresh_c: cover property (refresh_i && running && !refresh_ok);
  stray_write_c: cover property (lock_state == WDRU_OPEN_MIDDLE && wr_i && addr_i != `WDRU_ADDR_MIDDLE);

endmodule

/* logic/wdru_consts.svh */
`ifndef WDRU_CONSTS_SVH
`define WDRU_CONSTS_SVH

// register offsets
`define WDRU_ADDR_UNLOCK  12'hFF0
`define WDRU_ADDR_UPPER   12'hFF1
`define WDRU_ADDR_MIDDLE  12'hFF2
`define WDRU_ADDR_LOWER   12'hFF3
`define WDRU_ADDR_IRQ_ST  12'hFF4
`define WDRU_ADDR_IRQ_MSK 12'hFF5

// unlock key bytes
`define WDRU_KEY_FIRST    8'h55
`define WDRU_KEY_SECOND   8'hAA

// reset values
`define WDRU_RST_UPPER    8'h00
`define WDRU_RST_MIDDLE   8'h04
`define WDRU_RST_LOWER    8'h00
`define WDRU_RST_COUNT    24'h000000
`define WDRU_RST_IRQ_MSK  2'h0

// refresh is refused at or below this count while running
`define WDRU_REFRESH_MIN  24'h000002

// reset status field positions
`define WDRU_RS_TIMEOUT   0
`define WDRU_RS_WDRESET   1

// event status field positions
`define WDRU_EV_TIMEOUT   0
`define WDRU_EV_RELOAD    1

`endif

/* logic/wdru_pkg.sv */
package wdru_pkg;

  typedef enum logic [2:0]
  {
    WDRU_LOCKED,
    WDRU_KEY1,
    WDRU_OPEN_UPPER,
    WDRU_OPEN_MIDDLE,
    WDRU_OPEN_LOWER
  } wdru_lock_e;

  typedef logic [23:0] wdru_count_t;

endpackage

/* logic/wdru_tick_sync.sv */
`timescale 1ns/1ps
module wdru_tick_sync
(
  input  wire logic clk_sys_i, // system clock
  input  wire logic rst_i,     // async reset, active high
  input  wire logic osc_i,     // slow oscillator pin
  output logic      tick_o     // one-cycle pulse per rising osc edge
);

  logic meta;
  logic sync;
  logic sync_d;

  // two flops before any logic, third flop only for edge detect
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      meta   <= 1'b0;
      sync   <= 1'b0;
      sync_d <= 1'b0;
    end
    else
    begin
      meta   <= osc_i;
      sync   <= meta;
      sync_d <= sync;
    end
  end

  assign tick_o = sync & ~sync_d;

endmodule

/* test/test_watchdog_reload_unlock_regs.sv */
`timescale 1ns/1ps
`define CHK(nm, ex, gt) \
  begin \
    total_checks++; \
    if ((gt) !== (ex)) \
    begin \
      error_cnt++; \
      $display("ERROR %s expected %0h seen %0h", nm, ex, gt); \
    end \
  end
module test_watchdog_reload_unlock_regs;
  import wdru_pkg::*;

  // row operations: 0 write, 1 read, 2 refresh, 3 slow tick, 4 irq level
  typedef struct
  {
    int          op;
    logic [11:0] a;
    logic [7:0]  d;
    logic [7:0]  e;
  } wdru_row_s;

  logic        clk_sys_i;
  logic        rst_i;
  logic [11:0] addr_i;
  logic [7:0]  wdata_i;
  logic        wr_i;
  logic        rd_i;
  logic [7:0]  rdata_o;
  logic        osc_i;
  logic        refresh_i;
  logic        resp_reset_i;
  logic        irq_o;
  logic        sys_reset_o;
  logic [7:0]  got;
  int          error_cnt    = 0;
  int          total_checks = 0;
  int          pulses       = 0;
  int          cyc          = 0;

  wdru_row_s rows [] = '{
    '{1, 12'hFF1, 8'h00, 8'h00}, '{1, 12'hFF0, 8'h00, 8'h00},
    '{1, 12'hFF6, 8'h00, 8'h00}, '{1, 12'hFF5, 8'h00, 8'h00},
    '{2, 12'h000, 8'h00, 8'h00}, '{1, 12'hFF1, 8'h00, 8'h00},
    '{1, 12'hFF2, 8'h00, 8'h04}, '{1, 12'hFF3, 8'h00, 8'h00},
    '{0, 12'hFF1, 8'h12, 8'h00}, '{0, 12'hFF0, 8'h55, 8'h00},
    '{0, 12'hFF0, 8'hAA, 8'h00}, '{0, 12'hFF1, 8'h00, 8'h00},
    '{0, 12'hFF2, 8'h00, 8'h00}, '{0, 12'hFF3, 8'h07, 8'h00},
    '{1, 12'hFF2, 8'h00, 8'h04}, '{1, 12'hFF4, 8'h00, 8'h02},
    '{0, 12'hFF3, 8'h09, 8'h00}, '{2, 12'h000, 8'h00, 8'h00},
    '{1, 12'hFF1, 8'h00, 8'h00}, '{1, 12'hFF2, 8'h00, 8'h00},
    '{1, 12'hFF3, 8'h00, 8'h07}, '{1, 12'hFF0, 8'h00, 8'h00},
    '{0, 12'hFF0, 8'h55, 8'h00}, '{0, 12'hFF0, 8'hAA, 8'h00},
    '{0, 12'hFF1, 8'h00, 8'h00}, '{0, 12'hFF5, 8'h00, 8'h00},
    '{0, 12'hFF2, 8'h01, 8'h00}, '{0, 12'hFF3, 8'h01, 8'h00},
    '{2, 12'h000, 8'h00, 8'h00}, '{1, 12'hFF2, 8'h00, 8'h00},
    '{1, 12'hFF3, 8'h00, 8'h07}, '{0, 12'hFF4, 8'h02, 8'h00},
    '{1, 12'hFF4, 8'h00, 8'h00}, '{3, 12'h000, 8'h00, 8'h00},
    '{3, 12'h000, 8'h00, 8'h00}, '{3, 12'h000, 8'h00, 8'h00},
    '{3, 12'h000, 8'h00, 8'h00}, '{3, 12'h000, 8'h00, 8'h00},
    '{1, 12'hFF3, 8'h00, 8'h02}, '{2, 12'h000, 8'h00, 8'h00},
    '{1, 12'hFF3, 8'h00, 8'h02}, '{3, 12'h000, 8'h00, 8'h00},
    '{3, 12'h000, 8'h00, 8'h00}, '{1, 12'hFF4, 8'h00, 8'h01},
    '{4, 12'h000, 8'h00, 8'h00}, '{0, 12'hFF5, 8'h01, 8'h00},
    '{4, 12'h000, 8'h00, 8'h01}, '{1, 12'hFF0, 8'h00, 8'h01},
    '{1, 12'hFF0, 8'h00, 8'h00}, '{3, 12'h000, 8'h00, 8'h00},
    '{1, 12'hFF1, 8'h00, 8'hFF}, '{1, 12'hFF3, 8'h00, 8'hFF},
    '{0, 12'hFF4, 8'h01, 8'h00}, '{4, 12'h000, 8'h00, 8'h00}
  };

  wdru_top dut
  (
    .clk_sys_i    (clk_sys_i),
    .rst_i        (rst_i),
    .addr_i       (addr_i),
    .wdata_i      (wdata_i),
    .wr_i         (wr_i),
    .rd_i         (rd_i),
    .rdata_o      (rdata_o),
    .osc_i        (osc_i),
    .refresh_i    (refresh_i),
    .resp_reset_i (resp_reset_i),
    .irq_o        (irq_o),
    .sys_reset_o  (sys_reset_o)
  );

  always #4 clk_sys_i = ~clk_sys_i;

  always @(posedge clk_sys_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      print_verdict();
    end
  end

  // pulse counted away from the edge that launches it
  always @(negedge clk_sys_i)
  begin
    if (sys_reset_o === 1'b1)
      pulses++;
  end

  // one strobe cycle, then one idle cycle; read data sampled in the cycle after
  task automatic bus(input logic w, input logic r, input logic [11:0] a, input logic [7:0] d);
    wr_i    <= w;
    rd_i    <= r;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    #1 got = rdata_o;
    @(posedge clk_sys_i);
  endtask

  task automatic run(input wdru_row_s r);
    case (r.op)
      0: bus(1'b1, 1'b0, r.a, r.d);
      1:
      begin
        bus(1'b0, 1'b1, r.a, 8'h00);
        `CHK("rdata", r.e, got)
      end
      2:
      begin
        refresh_i <= 1'b1;
        @(posedge clk_sys_i);
        refresh_i <= 1'b0;
        @(posedge clk_sys_i);
      end
      3:
      begin
        osc_i <= 1'b1;
        repeat (6) @(posedge clk_sys_i);
        osc_i <= 1'b0;
        repeat (6) @(posedge clk_sys_i);
      end
      default:
      begin
        #1;
        `CHK("irq", r.e[0], irq_o)
      end
    endcase
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    clk_sys_i    = 1'b0;
    rst_i        = 1'b1;
    addr_i       = 12'h000;
    wdata_i      = 8'h00;
    wr_i         = 1'b0;
    rd_i         = 1'b0;
    osc_i        = 1'b0;
    refresh_i    = 1'b0;
    resp_reset_i = 1'b0;
    repeat (5) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(posedge clk_sys_i);
    foreach (rows[i])
      run(rows[i]);
    // reset response: refresh at the wrap value reloads the stored reload value 7, seven ticks to zero
    resp_reset_i <= 1'b1;
    run('{2, 12'h000, 8'h00, 8'h00});
    repeat (7) run('{3, 12'h000, 8'h00, 8'h00});
    `CHK("reset pulses", 1, pulses)
    run('{1, 12'hFF0, 8'h00, 8'h03});
    run('{1, 12'hFF4, 8'h00, 8'h00});
    // second reset in mid-run restores the reload value and stops the counter
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    #1;
    `CHK("irq in reset", 1'b0, irq_o)
    `CHK("sysreset in reset", 1'b0, sys_reset_o)
    rst_i <= 1'b0;
    @(posedge clk_sys_i);
    run('{1, 12'hFF2, 8'h00, 8'h00});
    run('{1, 12'hFF5, 8'h00, 8'h00});
    run('{2, 12'h000, 8'h00, 8'h00});
    run('{1, 12'hFF2, 8'h00, 8'h04});
    print_verdict();
  end
endmodule
